// ==== pwm_pkg.sv ====
`default_nettype none
package pwm_pkg;
  // ---------------------------------------------------------------
  // Sizes and clocking
  // ---------------------------------------------------------------
  localparam int NUM_CH = 6;
  localparam int SYS_CLK_MHZ = 100;
  localparam int MASTER_CLK_MHZ = 16;
  localparam logic [7:0] PHASE_INC = 8'(MASTER_CLK_MHZ);
  localparam logic [7:0] PHASE_MOD = 8'(SYS_CLK_MHZ);
  localparam logic [2:0] PSC_MAX = 3'h6;
  localparam logic [6:0] DIV_STEP = 7'h01;
  localparam logic [15:0] CNT_STEP = 16'h0001;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses within the block)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_GLOBAL = 8'h00;
  localparam logic [7:0] OFF_CTRL0 = 8'h04;
  localparam logic [7:0] OFF_LIMIT0 = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h44;
  localparam logic [7:0] BANK_SPAN = 8'(4 * NUM_CH);

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int GLB_EN0_BIT = 0;
  localparam int GLB_EN1_BIT = 4;
  localparam int CTRL_PSC_LSB = 0;
  localparam int CTRL_POL_BIT = 4;
  localparam int CTRL_MODE_BIT = 8;
  localparam int CTRL_EN_BIT = 12;
  localparam int CTRL_LOAD_BIT = 16;
  localparam int LIMIT_THR_LSB = 0;
  localparam int LIMIT_TOP_LSB = 16;
  localparam int STAT_EN_LSB = 8;

  typedef enum logic {DIR_UP, DIR_DOWN} dir_e;

  // Prescaler code p divides by 2^(p+1); codes above 6 act as 128
  function automatic logic [6:0] psc_mask(input logic [2:0] psc);
    logic [2:0] p;
    p = (psc > PSC_MAX) ? PSC_MAX : psc;
    return 7'((8'h02 << p) - 8'h01);
  endfunction

  function automatic logic in_bank(input logic [7:0] off,
                                   input logic [7:0] base);
    return (off >= base) && (off < 8'(base + BANK_SPAN)) &&
           (off[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] ch_index(input logic [7:0] off,
                                          input logic [7:0] base);
    logic [7:0] d;
    d = 8'(off - base);
    return d[4:2];
  endfunction
endpackage
`default_nettype wire

// ==== pwm_channel.sv ====
`timescale 1ns/1ns
`default_nettype none
module pwm_channel
  import pwm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic master_tick,
  input wire logic enable,
  input wire logic load,
  input wire logic [2:0] psc,
  input wire logic polarity,
  input wire logic updown,
  input wire logic [15:0] top,
  input wire logic [15:0] thr,
  output logic pwm_out,
  output logic pending
);
  typedef struct packed {
    logic [6:0] div;
    logic [15:0] cnt;
    dir_e dir;
    logic [2:0] psc;
    logic pol;
    logic mode;
    logic [15:0] top;
    logic [15:0] thr;
    logic pend;
    logic out;
  } chan_s;

  chan_s q, d;

  // ---------------------------------------------------------------
  // Counter, shadow load and output
  // ---------------------------------------------------------------
  always_comb begin
    logic boundary;
    boundary = 1'b0;
    d = q;
    d.pend = q.pend | load;
    if (!enable) begin
      d.div = '0;
      d.cnt = '0;
      d.dir = DIR_UP;
      boundary = 1'b1;
    end else if (master_tick) begin
      if ((q.div & psc_mask(q.psc)) == psc_mask(q.psc)) begin
        d.div = '0;
        if (!q.mode) begin
          if (q.cnt >= q.top) begin
            d.cnt = '0;
            boundary = 1'b1;
          end else begin
            d.cnt = q.cnt + CNT_STEP;
          end
        end else if (q.dir == DIR_UP) begin
          if (q.cnt >= q.top) begin
            d.dir = DIR_DOWN;
            d.cnt = (q.cnt == '0) ? q.cnt : q.cnt - CNT_STEP;
          end else begin
            d.cnt = q.cnt + CNT_STEP;
          end
        end else if (q.cnt == '0) begin
          d.dir = DIR_UP;
          boundary = 1'b1;
          d.cnt = (q.top == '0) ? q.cnt : q.cnt + CNT_STEP;
        end else begin
          d.cnt = q.cnt - CNT_STEP;
        end
      end else begin
        d.div = q.div + DIV_STEP;
      end
    end
    // Settings change only between periods, so no runt pulses
    if (boundary && d.pend) begin
      d.psc = psc;
      d.pol = polarity;
      d.mode = updown;
      d.top = top;
      d.thr = thr;
      d.pend = load;
    end
    if (!enable) begin
      d.out = ~d.pol;
    end else begin
      d.out = (d.cnt < d.thr) ? d.pol : ~d.pol;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{div: '0, cnt: '0, dir: DIR_UP, psc: '0, pol: 1'b0,
             mode: 1'b0, top: '0, thr: '0, pend: 1'b0, out: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign pwm_out = q.out;
  assign pending = q.pend;
endmodule // pwm_channel
`default_nettype wire

// ==== six_channel_pwm.sv ====
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Six independent channels, own settings each
// - Power-of-two prescale 2..128, 3-bit code
// - Up mode: count zero to top, wrap
// - Output changes where counter meets threshold
// - Polarity picks level below threshold
// - Up/down mode reverses at top
// - Mode, enable and load-enable bits per channel
// - Channel registers span offsets 0x04..0x30
// - Global bits 0 and 4 gate channel programming
module six_channel_pwm
  import pwm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NUM_CH-1:0] pwm_out
);
  typedef struct packed {
    logic [7:0] phase;
    logic tick;
    logic [1:0] glb;
    logic [NUM_CH-1:0][2:0] psc;
    logic [NUM_CH-1:0] pol;
    logic [NUM_CH-1:0] mode;
    logic [NUM_CH-1:0] en;
    logic [NUM_CH-1:0] load;
    logic [NUM_CH-1:0][15:0] top;
    logic [NUM_CH-1:0][15:0] thr;
    logic [31:0] rdata;
  } regs_s;

  regs_s q, d;
  logic [NUM_CH-1:0] pend;
  logic err;

  // ---------------------------------------------------------------
  // Master clock enable, APB register file
  // ---------------------------------------------------------------
  always_comb begin
    logic setup;
    logic access;
    logic prog_ok;
    logic is_ctrl;
    logic is_limit;
    logic [2:0] ci;
    logic [2:0] li;
    logic [8:0] ph;
    setup = psel & ~penable;
    access = psel & penable;
    prog_ok = q.glb[0] & q.glb[1];
    is_ctrl = in_bank(paddr, OFF_CTRL0);
    is_limit = in_bank(paddr, OFF_LIMIT0);
    ci = ch_index(paddr, OFF_CTRL0);
    li = ch_index(paddr, OFF_LIMIT0);
    d = q;
    d.load = '0;
    // 16 MHz master rate from the 100 MHz clock by phase accumulation
    ph = {1'b0, q.phase} + {1'b0, PHASE_INC};
    d.tick = (ph >= {1'b0, PHASE_MOD});
    d.phase = d.tick ? 8'(ph - {1'b0, PHASE_MOD}) : ph[7:0];
    err = 1'b0;
    if (setup) begin
      d.rdata = '0;
      if (paddr == OFF_GLOBAL) begin
        d.rdata[GLB_EN0_BIT] = q.glb[0];
        d.rdata[GLB_EN1_BIT] = q.glb[1];
      end else if (is_ctrl) begin
        d.rdata[CTRL_PSC_LSB +: 3] = q.psc[ci];
        d.rdata[CTRL_POL_BIT] = q.pol[ci];
        d.rdata[CTRL_MODE_BIT] = q.mode[ci];
        d.rdata[CTRL_EN_BIT] = q.en[ci];
        d.rdata[CTRL_LOAD_BIT] = pend[ci];
      end else if (is_limit) begin
        d.rdata[LIMIT_TOP_LSB +: 16] = q.top[li];
        d.rdata[LIMIT_THR_LSB +: 16] = q.thr[li];
      end else if (paddr == OFF_STATUS) begin
        d.rdata[0 +: NUM_CH] = pwm_out;
        d.rdata[STAT_EN_LSB +: NUM_CH] = q.en;
      end
    end
    if (access) begin
      if (paddr == OFF_GLOBAL) begin
        if (pwrite) begin
          d.glb = {pwdata[GLB_EN1_BIT], pwdata[GLB_EN0_BIT]};
        end
      end else if (is_ctrl) begin
        if (pwrite && prog_ok) begin
          d.psc[ci] = pwdata[CTRL_PSC_LSB +: 3];
          d.pol[ci] = pwdata[CTRL_POL_BIT];
          d.mode[ci] = pwdata[CTRL_MODE_BIT];
          d.en[ci] = pwdata[CTRL_EN_BIT];
          d.load[ci] = pwdata[CTRL_LOAD_BIT];
        end else if (pwrite) begin
          err = 1'b1;
        end
      end else if (is_limit) begin
        if (pwrite && prog_ok) begin
          d.top[li] = pwdata[LIMIT_TOP_LSB +: 16];
          d.thr[li] = pwdata[LIMIT_THR_LSB +: 16];
        end else if (pwrite) begin
          err = 1'b1;
        end
      end else if (paddr == OFF_STATUS) begin
        err = pwrite;
      end else begin
        err = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pready = 1'b1;
  assign pslverr = err;
  assign prdata = q.rdata;

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    pwm_channel u_ch (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .master_tick(q.tick),
      .enable(q.en[i]),
      .load(q.load[i]),
      .psc(q.psc[i]),
      .polarity(q.pol[i]),
      .updown(q.mode[i]),
      .top(q.top[i]),
      .thr(q.thr[i]),
      .pwm_out(pwm_out[i]),
      .pending(pend[i])
    );
  end
endmodule // six_channel_pwm
`default_nettype wire

// ==== pwm_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module pwm_asserts
  import pwm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_CH-1:0] pwm_out
);
  // ---------------------------------------------------------------
  // Bus checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  logic glb_q;
  logic acc;
  logic chw;
  logic chmap;
  assign acc = psel && penable;
  assign chw = acc && pwrite && paddr >= 8'h04 && paddr <= 8'h40;
  // Mapped channel words: control and limit banks, aligned
  assign chmap = paddr >= OFF_CTRL0 && paddr < 8'(OFF_LIMIT0 + BANK_SPAN) &&
    paddr[1:0] == 2'h0;
  // Tracks whether channel programming is unlocked
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      glb_q <= 1'b0;
    end else if (acc && pwrite && paddr == OFF_GLOBAL) begin
      glb_q <= pwdata[GLB_EN0_BIT] & pwdata[GLB_EN1_BIT];
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_status_rd;
    s_setup ##1 (s_access and (!pwrite && paddr == OFF_STATUS));
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_idle: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access");
  a_locked_refused: assert property (chw && !glb_q |-> pslverr)
    else $error("locked channel write accepted");
  a_open_accepted: assert property (chw && glb_q && chmap |-> !pslverr)
    else $error("unlocked channel write refused");
  a_gap_refused: assert property (chw && !chmap |-> pslverr)
    else $error("unmapped channel word accepted");
  a_status_ro: assert property (
    acc && pwrite && paddr == OFF_STATUS |-> pslverr)
    else $error("status write accepted");
  a_outside_err: assert property (acc && paddr > OFF_STATUS |-> pslverr)
    else $error("unmapped access accepted");
  a_outside_zero: assert property (
    acc && !pwrite && paddr > OFF_STATUS |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (
    s_setup ##1 s_access |=> $stable(prdata))
    else $error("read data moved after access");
  a_status_live: assert property (
    s_status_rd |-> prdata[NUM_CH-1:0] == $past(pwm_out))
    else $error("status does not show outputs");
endmodule // pwm_asserts
bind six_channel_pwm pwm_asserts chk_u (.sys_clk(sys_clk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pwm_out(pwm_out));
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb
  import pwm_pkg::*;
;
  logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, err;
  logic [5:0] pwm_out;
  int n_fail = 0, tests_run = 0;
  six_channel_pwm dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out));
  initial forever #5 sys_clk = ~sys_clk;
  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("fails %0d checks %0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_fail++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic all(input logic [31:0] ctl);
    for (int c = 0; c < 6; c++) apb(1, 8'(8'h04 + 4 * c), ctl);
  endtask
  task automatic cfg(input logic [31:0] ctl);
    for (int c = 0; c < 6; c++) apb(1, 8'(8'h1C + 4 * c), 32'h0003_0001);
    all(ctl | 32'h0001_0000);
    all(ctl | 32'h0000_1000);
  endtask
  // Counts high cycles and rising edges of every channel over 2400 cycles
  task automatic meas(input int hx, input int rx);
    int hi[6];
    int ri[6];
    logic [5:0] p;
    hi = '{default: 0};
    ri = '{default: 0};
    p = pwm_out;
    repeat (2400) begin
      @(posedge sys_clk);
      foreach (hi[c]) hi[c] += int'(pwm_out[c]);
      foreach (ri[c]) ri[c] += int'(pwm_out[c] & ~p[c]);
      p = pwm_out;
    end
    foreach (hi[c])
      chk(32'(hi[c] > hx - 30 && hi[c] < hx + 30), 32'h1);
    foreach (ri[c])
      chk(32'(ri[c] >= rx - 2 && ri[c] <= rx + 2), 32'h1);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    chk(pwm_out, 32'h3F);
    reset_n <= 1;
    apb(1, 8'h04, 32'h0000_0001);
    chk(err, 32'h1);
    apb(0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    apb(1, 8'h00, 32'h0000_0011);
    apb(0, 8'h00, 32'h0);
    chk(rd, 32'h11);
    apb(1, 8'h44, 32'h0);
    chk(err, 32'h1);
    apb(1, 8'h34, 32'h0);
    chk(err, 32'h1);
    apb(0, 8'h48, 32'h0);
    chk(rd | err, 32'h1);
    $display("test access done");
    cfg(32'h0010);
    meas(600, 48);
    cfg(32'h0000);
    meas(1800, 48);
    cfg(32'h0110);
    meas(400, 32);
    cfg(32'h0012);
    meas(600, 12);
    all(32'h0000_1010);
    meas(600, 12);
    $display("test waveforms done");
    all(32'h0010);
    apb(0, 8'h44, 32'h0);
    chk(rd[13:0], 32'h0);
    apb(1, 8'h00, 32'h0000_0001);
    apb(1, 8'h1C, 32'h0);
    chk(err, 32'h1);
    $display("test disable done");
    final_report();
  end
endmodule // tb
`default_nettype wire
